/* hdl/apdu_pkg.sv */
// constants, field layouts and types shared by the card transport responder
// ==========================================================================
package apdu_pkg;

  // ========================================================================
  // instruction codes
  localparam logic [7:0] INS_SELECT = 8'hA4;
  localparam logic [7:0] INS_READ = 8'hB0;
  localparam logic [7:0] INS_UPDATE = 8'hD6;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_GET_RESP = 8'hC0;

  // ========================================================================
  // parameter bytes accepted as valid
  localparam logic [7:0] P1_OK = 8'h00;
  localparam logic [7:0] P2_BINARY_OK = 8'h00;
  localparam logic [7:0] P2_SELECT_OK = 8'h04;
  localparam logic [7:0] P2_VERIFY_OK = 8'h01;

  // ========================================================================
  // status and procedure bytes
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] SW1_BAD_PARAM = 8'h6A;
  localparam logic [7:0] SW2_BAD_PARAM = 8'h86;
  localparam logic [7:0] SW2_NOT_FOUND = 8'h82;
  localparam logic [7:0] SW1_FIX_LEN = 8'h6C;
  localparam logic [7:0] SW1_MORE = 8'h61;
  localparam logic [7:0] SW1_WARN = 8'h63;
  localparam logic [3:0] SW2_TRIES_HI = 4'hC;
  localparam logic [7:0] SW1_BAD_INS = 8'h6D;
  localparam logic [7:0] SW2_ZERO = 8'h00;
  localparam logic [7:0] SW1_REFUSED = 8'h69;
  localparam logic [7:0] SW2_NO_PENDING = 8'h85;
  localparam logic [7:0] SW2_BLOCKED = 8'h83;

  // ========================================================================
  // file, secret and buffer sizes
  localparam int FILE_WORDS = 16;
  localparam logic [7:0] FILE_LEN = 8'h0B;
  localparam logic [15:0] FILE_ID = 16'h6F7E;   // arbitrary value
  localparam logic [31:0] PIN_VALUE = 32'h31323334; // arbitrary value
  localparam logic [3:0] TRIES_MAX = 4'h3;
  localparam logic [7:0] FCP_LEN = 8'h04;
  localparam logic [7:0] FCP_TAG = 8'h62;
  localparam logic [7:0] FCP_INNER_LEN = 8'h02;
  localparam logic [7:0] FCP_SIZE_TAG = 8'h80;
  localparam int RESP_DEPTH = 8;

  // ========================================================================
  // byte carriers and controller states
  typedef struct packed {
    logic last; // end of information field (block protocol)
    logic [7:0] data; // byte value
  } cmd_byte_t;

  typedef struct packed {
    logic last; // final byte of the response unit
    logic [7:0] data; // byte value
  } resp_byte_t;

  typedef enum logic [3:0] {
    ST_HDR = 4'h0,
    ST_DECIDE = 4'h1,
    ST_RX = 4'h2,
    ST_DRAIN = 4'h3,
    ST_EXEC = 4'h4,
    ST_TX_ACK = 4'h5,
    ST_TX_DATA = 4'h6,
    ST_TX_SW1 = 4'h7,
    ST_TX_SW2 = 4'h8
  } state_t;

endpackage

/* hdl/resp_fifo.sv */
// response byte fifo with valid and ready on both sides
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk, // core clock
  input wire logic reset, // asynchronous, active high
  input wire logic in_valid, // producer offers a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word offered
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // consumer takes it
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // storage and pointers, one extra bit to tell full from empty
  logic [WIDTH-1:0] mem [DEPTH]; // word store
  logic [AW:0] wr_ptr; // write pointer
  logic [AW:0] rd_ptr; // read pointer
  logic [AW:0] next_wr_ptr; // next write pointer
  logic [AW:0] next_rd_ptr; // next read pointer
  logic full; // all entries used
  logic empty; // no entries used
  logic push; // word accepted
  logic pop; // word delivered

  // status and next pointers
  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    in_ready = !full;
    out_valid = !empty;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && !full;
    pop = out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // pointer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // word store, no reset needed since empty hides it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

/* hdl/card_apdu_transport_responder.sv */
// card side command interpreter for character and block transport
`timescale 1ns/1ps
module card_apdu_transport_responder (
  input wire logic core_clk, // 125 MHz core clock
  input wire logic reset, // asynchronous, active high
  input wire logic block_mode, // 1 = block protocol, 0 = character
  input wire logic cmd_valid, // terminal offers a command byte
  output logic cmd_ready, // byte is taken
  input apdu_pkg::cmd_byte_t cmd, // command byte and end marker
  output logic resp_valid, // response byte waiting
  input wire logic resp_ready, // terminal takes the byte
  output apdu_pkg::resp_byte_t resp, // response byte and end marker
  output logic [3:0] tries_left, // verification attempts left
  output logic pin_verified, // secret presented correctly
  output logic pending_resp // fetchable data is held
);

  // ========================================================================
  // controller state, each register beside its next value
  apdu_pkg::state_t state, next_state; // current step
  logic [2:0] idx, next_idx; // header byte index
  logic [7:0] ins, next_ins; // instruction
  logic [7:0] p1, next_p1; // first parameter
  logic [7:0] p2, next_p2; // second parameter
  logic [7:0] p3, next_p3; // length byte
  logic hdr_last, next_hdr_last; // information field ended in header
  logic [7:0] cnt, next_cnt; // bytes left to move
  logic [7:0] ptr, next_ptr; // byte offset in source
  logic [7:0] sw1, next_sw1; // first status byte
  logic [7:0] sw2, next_sw2; // second status byte
  logic ack, next_ack; // send instruction as acknowledge
  logic src_fcp, next_src_fcp; // data comes from control parameters
  logic decided, next_decided; // status fixed before draining input
  logic [7:0] pend_len, next_pend_len; // fetchable bytes left
  logic [7:0] pend_off, next_pend_off; // fetch offset
  logic [3:0] tries, next_tries; // attempts left
  logic verified, next_verified; // secret accepted
  logic [15:0] id_val, next_id_val; // file id collected
  logic [31:0] pin_val, next_pin_val; // secret collected

  // ========================================================================
  // file store, written by update and read by read
  logic [7:0] mem [apdu_pkg::FILE_WORDS]; // file bytes
  logic mem_we; // write strobe; address is ptr, data the command byte

  // ========================================================================
  // path into the response fifo
  logic push_valid; // byte offered to fifo
  logic push_ready; // fifo has room
  apdu_pkg::resp_byte_t push_data; // byte offered
  logic fire; // byte accepted by fifo
  logic take; // command byte accepted
  logic [7:0] le_read; // length served for read
  logic [7:0] le_fetch; // length served for fetch
  logic p2_ok; // second parameter valid for instruction

  // control parameter bytes of the one selectable file
  function automatic logic [7:0] fcp_byte(input logic [1:0] i);
    logic [7:0] b;
    case (i)
      2'h0: b = apdu_pkg::FCP_TAG;
      2'h1: b = apdu_pkg::FCP_INNER_LEN;
      2'h2: b = apdu_pkg::FCP_SIZE_TAG;
      default: b = apdu_pkg::FILE_LEN;
    endcase
    return b;
  endfunction

  // ========================================================================
  // fifo byte selection and handshakes
  always_comb begin
    cmd_ready = (state == apdu_pkg::ST_HDR) || (state == apdu_pkg::ST_RX) ||
                (state == apdu_pkg::ST_DRAIN);
    take = cmd_ready && cmd_valid;
    push_data.last = 1'b0;
    push_data.data = apdu_pkg::SW2_ZERO;
    push_valid = 1'b0;
    case (state)
      apdu_pkg::ST_TX_ACK: begin // acknowledge, only when asked for
        push_valid = ack;
        push_data.data = ins;
      end
      apdu_pkg::ST_TX_DATA: begin // data bytes from file or parameters
        push_valid = (cnt != 8'h00);
        push_data.data = src_fcp ? fcp_byte(ptr[1:0]) : mem[ptr[3:0]];
      end
      apdu_pkg::ST_TX_SW1: begin
        push_valid = 1'b1;
        push_data.data = sw1;
      end
      apdu_pkg::ST_TX_SW2: begin // closes the response unit
        push_valid = 1'b1;
        push_data.data = sw2;
        push_data.last = 1'b1;
      end
      default: push_valid = 1'b0; // idle states offer nothing
    endcase
    fire = push_valid && push_ready;
    // in block framing, zero or oversize requests are served the whole file
    le_read = ((p3 == 8'h00) || (p3 > apdu_pkg::FILE_LEN)) ? apdu_pkg::FILE_LEN : p3;
    le_fetch = ((p3 == 8'h00) || (p3 > pend_len)) ? pend_len : p3;
    case (ins)
      apdu_pkg::INS_SELECT: p2_ok = (p2 == apdu_pkg::P2_SELECT_OK);
      apdu_pkg::INS_VERIFY: p2_ok = (p2 == apdu_pkg::P2_VERIFY_OK);
      default: p2_ok = (p2 == apdu_pkg::P2_BINARY_OK);
    endcase
  end

  // ========================================================================
  // next values for the whole command sequence
  always_comb begin
    // every register holds unless a state below moves it
    next_state = state;
    next_tries = tries;
    {next_idx, next_ins, next_p1, next_p2, next_p3} = {idx, ins, p1, p2, p3};
    {next_hdr_last, next_cnt, next_ptr, next_sw1, next_sw2} = {hdr_last, cnt, ptr, sw1, sw2};
    {next_ack, next_src_fcp, next_decided, next_verified} = {ack, src_fcp, decided, verified};
    {next_pend_len, next_pend_off, next_id_val, next_pin_val} = {pend_len, pend_off, id_val, pin_val};
    mem_we = 1'b0;
    case (state)
      apdu_pkg::ST_HDR: begin // collect class, ins, p1, p2, length
        if (take) begin
          next_idx = idx + 3'h1;
          case (idx)
            3'h1: next_ins = cmd.data;
            3'h2: next_p1 = cmd.data;
            3'h3: next_p2 = cmd.data;
            3'h4: next_p3 = cmd.data;
            default: next_p3 = 8'h00; // class byte, length not yet seen
          endcase
          // block unit may end after p2: a case 1 command
          if ((idx == 3'h4) || (block_mode && cmd.last)) begin
            next_state = apdu_pkg::ST_DECIDE;
            next_hdr_last = block_mode && cmd.last;
            next_idx = 3'h0;
          end
        end
      end
      apdu_pkg::ST_DECIDE: begin // judge the header
        next_state = apdu_pkg::ST_TX_ACK;
        next_ack = 1'b0;
        next_cnt = 8'h00;
        next_ptr = 8'h00;
        next_src_fcp = 1'b0;
        next_decided = 1'b0;
        next_sw1 = apdu_pkg::SW1_OK;
        next_sw2 = apdu_pkg::SW2_OK;
        // any command but a fetch throws the held data away
        if (ins != apdu_pkg::INS_GET_RESP) begin
          next_pend_len = 8'h00;
        end
        if ((p1 != apdu_pkg::P1_OK) || !p2_ok) begin
          // parameters refused whatever the length byte
          next_sw1 = apdu_pkg::SW1_BAD_PARAM;
          next_sw2 = apdu_pkg::SW2_BAD_PARAM;
          if (block_mode && !hdr_last) begin // body still arriving
            next_decided = 1'b1;
            next_state = apdu_pkg::ST_DRAIN;
          end
        end else begin
          case (ins)
            apdu_pkg::INS_READ: begin
              if (block_mode) begin // data then status in one unit
                next_cnt = le_read;
              end else if (p3 == apdu_pkg::FILE_LEN) begin
                // acknowledge, data, normal ending
                next_ack = 1'b1;
                next_cnt = apdu_pkg::FILE_LEN;
              end else if (le_read == apdu_pkg::FILE_LEN) begin
                // length unusable: tell the terminal the real one
                next_sw1 = apdu_pkg::SW1_FIX_LEN;
                next_sw2 = apdu_pkg::FILE_LEN;
              end else begin // shorter read served as asked
                next_ack = 1'b1;
                next_cnt = p3;
              end
            end
            apdu_pkg::INS_GET_RESP: begin
              if (pend_len == 8'h00) begin // nothing to fetch
                next_sw1 = apdu_pkg::SW1_REFUSED;
                next_sw2 = apdu_pkg::SW2_NO_PENDING;
              end else if (!block_mode && (p3 > pend_len)) begin
                // terminal overshot the announced length
                next_sw1 = apdu_pkg::SW1_FIX_LEN;
                next_sw2 = pend_len;
              end else begin
                next_ack = !block_mode;
                next_src_fcp = 1'b1;
                next_cnt = le_fetch;
                next_ptr = pend_off;
                next_pend_off = pend_off + le_fetch;
                next_pend_len = pend_len - le_fetch;
                if (pend_len != le_fetch) begin // more remains held
                  next_sw1 = apdu_pkg::SW1_MORE;
                  next_sw2 = pend_len - le_fetch;
                end
              end
            end
            apdu_pkg::INS_UPDATE, apdu_pkg::INS_SELECT, apdu_pkg::INS_VERIFY: begin
              if ((ins == apdu_pkg::INS_VERIFY) && ((p3 == 8'h00) || hdr_last)) begin
                // empty check: report attempts left, status only
                next_sw1 = apdu_pkg::SW1_WARN;
                next_sw2 = {apdu_pkg::SW2_TRIES_HI, tries};
                next_decided = 1'b1;
                next_state = (block_mode && !hdr_last) ? apdu_pkg::ST_DRAIN : apdu_pkg::ST_TX_ACK;
              end else if (block_mode) begin // body follows directly
                next_cnt = p3;
                next_state = apdu_pkg::ST_RX;
              end else begin // acknowledge, then body
                next_ack = 1'b1;
                next_cnt = p3;
                next_state = apdu_pkg::ST_TX_ACK;
              end
            end
            default: begin // unknown instruction
              next_sw1 = apdu_pkg::SW1_BAD_INS;
              next_sw2 = apdu_pkg::SW2_ZERO;
              if (block_mode && !hdr_last) begin
                next_decided = 1'b1;
                next_state = apdu_pkg::ST_DRAIN;
              end
            end
          endcase
        end
      end
      apdu_pkg::ST_RX: begin // take the command body
        if (cnt == 8'h00) begin
          next_state = apdu_pkg::ST_EXEC;
        end else if (take) begin
          next_cnt = cnt - 8'h01;
          next_ptr = ptr + 8'h01;
          next_id_val = {id_val[7:0], cmd.data};
          next_pin_val = {pin_val[23:0], cmd.data};
          // bytes past the store are dropped, not wrapped
          mem_we = (ins == apdu_pkg::INS_UPDATE) && (ptr[7:4] == 4'h0);
          if (cnt == 8'h01) begin
            // a trailing length byte may still sit in the block
            next_state = (block_mode && !cmd.last) ? apdu_pkg::ST_DRAIN : apdu_pkg::ST_EXEC;
          end
        end
      end
      apdu_pkg::ST_DRAIN: begin // discard rest of information field
        if (take && cmd.last) begin
          next_state = decided ? apdu_pkg::ST_TX_ACK : apdu_pkg::ST_EXEC;
        end
      end
      apdu_pkg::ST_EXEC: begin // act on the received body
        next_state = apdu_pkg::ST_TX_ACK;
        next_ack = 1'b0;
        next_cnt = 8'h00;
        next_ptr = 8'h00;
        next_sw1 = apdu_pkg::SW1_OK;
        next_sw2 = apdu_pkg::SW2_OK;
        case (ins)
          apdu_pkg::INS_SELECT: begin
            if (id_val != apdu_pkg::FILE_ID) begin
              // failed case 4: error pair only, never normal ending
              next_sw1 = apdu_pkg::SW1_BAD_PARAM;
              next_sw2 = apdu_pkg::SW2_NOT_FOUND;
            end else if (block_mode) begin
              // parameters and normal ending in the same unit
              next_src_fcp = 1'b1;
              next_cnt = apdu_pkg::FCP_LEN;
            end else begin
              // announce the fetchable length and hold it
              next_sw1 = apdu_pkg::SW1_MORE;
              next_sw2 = apdu_pkg::FCP_LEN;
              next_pend_len = apdu_pkg::FCP_LEN;
              next_pend_off = 8'h00;
            end
          end
          apdu_pkg::INS_VERIFY: begin
            if (tries == 4'h0) begin // locked out
              next_sw1 = apdu_pkg::SW1_REFUSED;
              next_sw2 = apdu_pkg::SW2_BLOCKED;
            end else if (pin_val == apdu_pkg::PIN_VALUE) begin
              next_tries = apdu_pkg::TRIES_MAX;
              next_verified = 1'b1;
            end else begin // wrong secret costs an attempt
              next_tries = tries - 4'h1;
              next_verified = 1'b0;
              next_sw1 = apdu_pkg::SW1_WARN;
              next_sw2 = {apdu_pkg::SW2_TRIES_HI, tries - 4'h1};
            end
          end
          default: begin // update: status only either way
            next_sw1 = apdu_pkg::SW1_OK;
          end
        endcase
      end
      apdu_pkg::ST_TX_ACK: begin // optional acknowledge byte
        if (!ack || fire) begin
          // character write: acknowledge then collect the body
          if (ack && (ins != apdu_pkg::INS_READ) && (ins != apdu_pkg::INS_GET_RESP)) begin
            next_state = apdu_pkg::ST_RX;
            next_ptr = 8'h00;
          end else begin
            next_state = apdu_pkg::ST_TX_DATA;
          end
          next_ack = 1'b0;
        end
      end
      apdu_pkg::ST_TX_DATA: begin // data bytes, back-pressured by fifo
        if (cnt == 8'h00) begin
          next_state = apdu_pkg::ST_TX_SW1;
        end else if (fire) begin
          next_cnt = cnt - 8'h01;
          next_ptr = ptr + 8'h01;
        end
      end
      apdu_pkg::ST_TX_SW1: begin
        if (fire) begin
          next_state = apdu_pkg::ST_TX_SW2;
        end
      end
      apdu_pkg::ST_TX_SW2: begin
        // a corrected length expects the same header again
        if (fire) begin
          next_state = apdu_pkg::ST_HDR;
        end
      end
      default: next_state = apdu_pkg::ST_HDR; // unused codes recover
    endcase
  end

  // ========================================================================
  // state registers; the attempt count comes out of reset full
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= apdu_pkg::ST_HDR;
      tries <= apdu_pkg::TRIES_MAX;
      {idx, ins, p1, p2, p3, hdr_last, cnt, ptr, sw1, sw2} <= '0;
      {ack, src_fcp, decided, verified, pend_len, pend_off, id_val, pin_val} <= '0;
    end else begin
      state <= next_state;
      tries <= next_tries;
      {idx, ins, p1, p2, p3} <= {next_idx, next_ins, next_p1, next_p2, next_p3};
      {hdr_last, cnt, ptr, sw1, sw2} <= {next_hdr_last, next_cnt, next_ptr, next_sw1, next_sw2};
      {ack, src_fcp, decided, verified} <= {next_ack, next_src_fcp, next_decided, next_verified};
      {pend_len, pend_off, id_val, pin_val} <= {next_pend_len, next_pend_off, next_id_val, next_pin_val};
    end
  end

  // file store write port; contents are zero after reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < apdu_pkg::FILE_WORDS; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (mem_we) begin
      mem[ptr[3:0]] <= cmd.data;
    end
  end

  // ========================================================================
  // response buffer; a stalled terminal stalls the controller
  resp_fifo #(.WIDTH($bits(apdu_pkg::resp_byte_t)), .DEPTH(apdu_pkg::RESP_DEPTH)) resp_fifo_inst (
    .clk(core_clk), .reset(reset), .in_valid(push_valid), .in_ready(push_ready), .in_data(push_data),
    .out_valid(resp_valid), .out_ready(resp_ready), .out_data(resp)
  );

  // tries_left and pin_verified straight from registers, pending_resp decoded from pend_len
  assign tries_left = tries;
  assign pin_verified = verified;
  assign pending_resp = (pend_len != 8'h00);
endmodule

/* bench/apdu_terminal_model.sv */
// terminal transport model: offers command bytes, drains response bytes
`timescale 1ns/1ps
module apdu_terminal_model (
  input wire logic core_clk, // core clock
  input wire logic reset, // active high
  input wire logic slow, // 1 = take a byte every other cycle
  output logic cmd_valid, // byte offered
  input wire logic cmd_ready, // byte taken
  output apdu_pkg::cmd_byte_t cmd, // byte and end marker
  input wire logic resp_valid, // byte waiting
  output logic resp_ready, // byte taken
  input apdu_pkg::resp_byte_t resp // byte and end marker
);
  apdu_pkg::cmd_byte_t tx_q[$]; // bytes still to offer
  logic [7:0] rx_q[$]; // bytes received
  logic rx_last; // end marker of the latest byte
  // one unit per call, end marker only in block framing
  task automatic send(input logic [7:0] b[$], input logic blk);
    foreach (b[i]) tx_q.push_back({blk && (i == b.size() - 1), b[i]});
  endtask
  // ==========================================
  // requests change after the falling edge and hold until taken
  always @(negedge core_clk) begin
    cmd_valid <= tx_q.size() > 0;
    cmd <= (tx_q.size() > 0) ? tx_q[0] : ~cmd; // idle line keeps changing
    resp_ready <= !reset && (!slow || !resp_ready);
  end
  // drop the byte just taken and collect each answer byte
  always @(posedge core_clk) begin
    if (cmd_valid && cmd_ready) void'(tx_q.pop_front());
    if (resp_valid && resp_ready) rx_q.push_back(resp.data);
    if (resp_valid && resp_ready) rx_last <= resp.last;
  end
endmodule

/* bench/apdu_responder_sva.sv */
// port checks for the card transport responder
`timescale 1ns/1ps
module apdu_responder_checker (
  input wire logic core_clk, // clock
  input wire logic reset, // active high
  input wire logic block_mode, // protocol
  input wire logic cmd_valid, // offer
  input wire logic cmd_ready, // take
  input apdu_pkg::cmd_byte_t cmd, // command byte
  input wire logic resp_valid, // byte waiting
  input wire logic resp_ready, // byte taken
  input apdu_pkg::resp_byte_t resp, // response byte
  input wire logic [3:0] tries_left, // attempts
  input wire logic pin_verified, // secret ok
  input wire logic pending_resp // data held
);
  // ==========================================
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_end; resp_valid && resp_ready && resp.last; endsequence
  AST_RESP_HOLD: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp))
    else $error("response byte changed while stalled");
  AST_PAIR_END: assert property (s_end |=> not s_end)
    else $error("response of one byte");
  AST_TRIES_MAX: assert property (tries_left <= apdu_pkg::TRIES_MAX)
    else $error("attempt count above maximum");
  AST_TRIES_STEP: assert property ($changed(tries_left) |->
    tries_left == $past(tries_left) - 4'h1 || tries_left == apdu_pkg::TRIES_MAX) else $error("attempt count jump");
  AST_RESET_STATE: assert property ($fell(reset) |-> cmd_ready && !resp_valid && !pending_resp)
    else $error("wrong state after reset");
  AST_PEND_CHAR: assert property ($rose(pending_resp) |-> !block_mode)
    else $error("data held back in block framing");
  AST_PEND_HOLD: assert property (pending_resp && cmd_ready && !cmd_valid |=> pending_resp)
    else $error("held data lost while idle");
  AST_ANSWER_BOUND: assert property (!cmd_ready |-> ##[1:300] cmd_ready)
    else $error("command never completed");
endmodule

/* bench/tb_card_apdu_transport_responder.sv */
// self-checking bench for the card transport responder
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_card_apdu_transport_responder;
  typedef logic [7:0] q_t[$]; // byte list
  logic core_clk, reset, block_mode, slow, cmd_valid, cmd_ready, resp_valid, resp_ready, pin_verified, pending_resp;
  logic [3:0] tries_left; // attempts
  apdu_pkg::cmd_byte_t cmd; // command byte
  apdu_pkg::resp_byte_t resp; // response byte
  int fail_count = 0;
  int total_checks = 0;
  q_t loci; // file contents written then read back
  card_apdu_transport_responder card_apdu_transport_responder_inst (.core_clk(core_clk), .reset(reset),
    .block_mode(block_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp(resp), .tries_left(tries_left), .pin_verified(pin_verified),
    .pending_resp(pending_resp));
  apdu_terminal_model apdu_terminal_model_inst (.core_clk(core_clk), .reset(reset), .slow(slow),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp(resp));
  // free running 8 ns clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic q_t o(input logic [63:0] v, input int n);
    q_t q;
    for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    return q;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // send one unit, collect the answer, then make sure nothing extra follows
  task automatic run(input q_t c, input q_t e);
    int n;
    apdu_terminal_model_inst.rx_q.delete();
    apdu_terminal_model_inst.send(c, block_mode);
    for (n = 0; n < 400 && apdu_terminal_model_inst.rx_q.size() < e.size(); n++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    `CHK(apdu_terminal_model_inst.rx_q.size(), e.size())
    foreach (e[i]) if (i < apdu_terminal_model_inst.rx_q.size()) `CHK(apdu_terminal_model_inst.rx_q[i], e[i])
    `CHK(apdu_terminal_model_inst.rx_last, 1'(e.size() > 1))
    if (n >= 400) begin
      fail_count++;
      finish_test();
    end
  endtask
  // update, verify, read and select cases in block framing
  task automatic t_block();
    block_mode = 1'b1;
    run({o(64'h00D600000B, 5), loci}, o(64'h9000, 2));
    run({o(64'h00D600010B, 5), o(64'h55, 1), loci}, o(64'h6A86, 2));
    run(o(64'h00200001, 4), o(64'h63C3, 2));
    run(o(64'h00200002, 4), o(64'h6A86, 2));
    run({o(64'h0020000104, 5), o(64'h0, 4)}, o(64'h63C2, 2));
    `CHK(tries_left, 4'h2)
    run({o(64'h0020000104, 5), o(64'h31323334, 4)}, o(64'h9000, 2));
    `CHK(pin_verified, 1'b1)
    run(o(64'h00B000000B, 5), {loci, o(64'h9000, 2)});
    run(o(64'h00A40004026F7E, 7), o(64'h6202800B9000, 6));
    run(o(64'h00A40104026F7E, 7), o(64'h6A86, 2));
    $display("block cases done");
  endtask
  task automatic t_char();
    block_mode = 1'b0;
    slow = 1'b1;
    run(o(64'h00B0000000, 5), o(64'h6C0B, 2));
    run(o(64'h00B000000B, 5), {o(64'hB0, 1), loci, o(64'h9000, 2)});
    slow = 1'b0;
    run(o(64'h00A4000402, 5), o(64'hA4, 1));
    run(o(64'h6F7E, 2), o(64'h6104, 2));
    `CHK(pending_resp, 1'b1)
    run(o(64'h00C0000004, 5), o(64'hC06202800B9000, 7));
    `CHK(pending_resp, 1'b0)
    run(o(64'h00C0000004, 5), o(64'h6985, 2));
    run(o(64'h00A4000402, 5), o(64'hA4, 1));
    run(o(64'h6F7E, 2), o(64'h6104, 2));
    run(o(64'h00C0000005, 5), o(64'h6C04, 2));
    run(o(64'h00C0000002, 5), o(64'hC062026102, 5));
    run(o(64'h00C0000002, 5), o(64'hC0800B9000, 5));
    run(o(64'h00A4000402, 5), o(64'hA4, 1));
    run(o(64'h6F00, 2), o(64'h6A82, 2));
    $display("character cases done");
  endtask
  // wrong second parameter, zero, oversize, exact and short lengths, both framings
  task automatic t_bad_param();
    logic [7:0] le[4] = '{8'h00, 8'h15, 8'h0B, 8'h05};
    for (int m = 0; m < 2; m++) begin
      block_mode = m[0];
      foreach (le[i]) run(o({32'h00B00001, le[i]}, 5), o(64'h6A86, 2));
    end
    $display("parameter cases done");
  endtask
  // hold reset, then run the scenarios in turn
  initial begin
    reset = 1'b1;
    block_mode = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 11; i++) loci.push_back(i < 9 ? 8'hA1 + 8'(i) : 8'h00);
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    t_block();
    t_char();
    t_bad_param();
    finish_test();
  end
endmodule
bind card_apdu_transport_responder apdu_responder_checker apdu_responder_checker_inst (.core_clk(core_clk),
  .reset(reset), .block_mode(block_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp), .tries_left(tries_left),
  .pin_verified(pin_verified), .pending_resp(pending_resp));
